// ==== core/rcpwm_top.v ====
// pwm generator: four own-period channels, eight shared-period channels, register port
`include "rcpwm_regs.vh"
module rcpwm_top (
    // clock and reset
    input wire clk,
    input wire rst,
    // register port
    input wire [11:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output wire [31:0] rdata,
    // pwm pins
    output wire [11:0] pwm_out
);
    localparam NCH = 12;
    localparam NCNT = 5;
    localparam integer PM_STEPS_I = `RCPWM_PM_STEPS;
    localparam integer TOP_I = `RCPWM_TOP;
    localparam integer PM_RLD_UP_I = `RCPWM_TOP - `RCPWM_PM_STEPS;
    localparam integer MIN_DN_I = `RCPWM_MIN_RLD_DN;
    localparam integer MIN_DN_PS_I = `RCPWM_MIN_RLD_DN_PS;
    localparam integer MAX_UP_I = `RCPWM_MAX_RLD_UP;
    localparam integer MAX_UP_PS_I = `RCPWM_MAX_RLD_UP_PS;
    localparam integer FMAX_I = `RCPWM_FMAX_HZ;
    localparam integer CLK_HZ_I = `RCPWM_CLK_HZ;
    // sized copies cut on purpose; every value fits its width
    localparam [16:0] PM_STEPS = PM_STEPS_I[16:0];
    localparam [16:0] TOP = TOP_I[16:0];
    localparam [15:0] PM_RLD_DN = PM_STEPS_I[15:0];
    localparam [15:0] PM_RLD_UP = PM_RLD_UP_I[15:0];
    localparam [15:0] MIN_DN = MIN_DN_I[15:0];
    localparam [15:0] MIN_DN_PS = MIN_DN_PS_I[15:0];
    localparam [15:0] MAX_UP = MAX_UP_I[15:0];
    localparam [15:0] MAX_UP_PS = MAX_UP_PS_I[15:0];
    localparam [12:0] FMAX = FMAX_I[12:0];
    localparam [9:0] PM_MUL = PM_STEPS_I[9:0];
    localparam [26:0] CLK_HZ = CLK_HZ_I[26:0];

    // software state
    reg [11:0] en_reg;
    reg [4:0] ps_reg;
    reg [4:0] pm_reg;
    reg [11:0] chg_reg;
    reg [11:0] den_reg;
    reg [15:0] reload_reg [0:NCNT-1];
    reg [12:0] freq_reg [0:NCNT-1];
    reg [15:0] duty_reg [0:NCH-1];
    reg [15:0] act_reg [0:NCH-1];
    reg [15:0] damp_reg [0:NCH-1];
    reg [15:0] ddiv_reg [0:NCH-1];
    reg [31:0] rdata_reg;
    reg [31:0] rd_val;

    wire s_dn;
    wire s_dn_ps;
    wire s_up;
    wire s_up_ps;
    wire [NCNT-1:0] run;
    wire [NCNT-1:0] wrap;
    wire [NCNT*16-1:0] cnt_bus;
    wire [NCH-1:0] out_bus;

    // address decode
    wire is_cnt = (addr[11:8] == `RCPWM_PAGE_CNT) && (addr[4:2] < 3'd5);
    wire [2:0] bank = addr[7:5];
    wire [2:0] k_idx = addr[4:2];
    wire is_chan = (addr[11:8] == `RCPWM_PAGE_CHAN) && (addr[7:4] < 4'd12);
    wire [3:0] ch_idx = addr[7:4];
    wire [1:0] sub = addr[3:2];

    integer i;

    rcpwm_tick u_tick (
        .clk(clk),
        .rst(rst),
        .tick_dn(s_dn),
        .tick_dn_ps(s_dn_ps),
        .tick_up(s_up),
        .tick_up_ps(s_up_ps)
    );

    // register writes; configuration holds until reset
    always @(posedge clk) begin
        if (rst) begin
            en_reg <= 12'h000;
            ps_reg <= 5'h00;
            pm_reg <= 5'h00;
            chg_reg <= 12'h000;
            den_reg <= 12'h000;
            for (i = 0; i < NCNT; i = i + 1) begin
                reload_reg[i] <= (i < `RCPWM_SHARED_IDX) ? `RCPWM_RST_RELOAD_DN : `RCPWM_RST_RELOAD_UP;
                freq_reg[i] <= `RCPWM_RST_FREQ;
            end
            for (i = 0; i < NCH; i = i + 1) begin
                duty_reg[i] <= `RCPWM_RST_DUTY;
                act_reg[i] <= `RCPWM_RST_DUTY;
                damp_reg[i] <= 16'h0000;
                ddiv_reg[i] <= 16'h0000;
            end
        end else begin
            if (wr) begin
                if (addr == `RCPWM_OFS_CHAN_EN) begin
                    en_reg <= wdata[11:0];
                end
                if (addr == `RCPWM_OFS_PRESCALE) begin
                    ps_reg <= wdata[4:0];
                end
                if (addr == `RCPWM_OFS_PERMILLE) begin
                    pm_reg <= wdata[4:0];
                end
                if (addr == `RCPWM_OFS_CHANGE) begin
                    chg_reg <= wdata[11:0];
                end
                if (addr == `RCPWM_OFS_DITHER_EN) begin
                    den_reg <= wdata[11:0];
                end
                if (is_cnt && bank == `RCPWM_BANK_RELOAD) begin
                    reload_reg[k_idx] <= wdata[15:0]; // RULE5 RULE7 RULE12
                end
                if (is_cnt && bank == `RCPWM_BANK_FREQ) begin
                    freq_reg[k_idx] <= wdata[12:0];
                end
                if (is_chan) begin
                    case (sub)
                        `RCPWM_SUB_DUTY: duty_reg[ch_idx] <= wdata[15:0];
                        `RCPWM_SUB_DAMP: damp_reg[ch_idx] <= wdata[15:0];
                        `RCPWM_SUB_DDIV: ddiv_reg[ch_idx] <= wdata[15:0];
                        default: ;
                    endcase
                end
            end
            // shadow duty reaches the comparator only while accepted
            for (i = 0; i < NCH; i = i + 1) begin
                if (chg_reg[i]) begin
                    act_reg[i] <= duty_reg[i]; // RULE18
                end
            end
        end
    end

    // read mux
    always @* begin
        rd_val = 32'h0000_0000;
        if (addr == `RCPWM_OFS_CHAN_EN) begin
            rd_val = {20'h00000, en_reg};
        end else if (addr == `RCPWM_OFS_PRESCALE) begin
            rd_val = {27'h0000000, ps_reg};
        end else if (addr == `RCPWM_OFS_PERMILLE) begin
            rd_val = {27'h0000000, pm_reg};
        end else if (addr == `RCPWM_OFS_CHANGE) begin
            rd_val = {20'h00000, chg_reg};
        end else if (addr == `RCPWM_OFS_DITHER_EN) begin
            rd_val = {20'h00000, den_reg};
        end else if (addr == `RCPWM_OFS_OUT_STAT) begin
            rd_val = {20'h00000, out_bus};
        end else if (is_cnt && bank == `RCPWM_BANK_RELOAD) begin
            rd_val = {16'h0000, reload_reg[k_idx]};
        end else if (is_cnt && bank == `RCPWM_BANK_FREQ) begin
            rd_val = {19'h00000, freq_reg[k_idx]};
        end else if (is_cnt && bank == `RCPWM_BANK_COUNT) begin
            rd_val = {16'h0000, cnt_bus[k_idx*16 +: 16]};
        end else if (is_chan) begin
            case (sub)
                `RCPWM_SUB_DUTY: rd_val = {16'h0000, duty_reg[ch_idx]};
                `RCPWM_SUB_DAMP: rd_val = {16'h0000, damp_reg[ch_idx]};
                `RCPWM_SUB_DDIV: rd_val = {16'h0000, ddiv_reg[ch_idx]};
                default: rd_val = {16'h0000, act_reg[ch_idx]};
            endcase
        end
    end

    // read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rd ? rd_val : 32'h0000_0000;
        end
    end
    assign rdata = rdata_reg;

    // period counters: 0..3 own, 4 shared by channels 4..11
    genvar k;
    generate
        for (k = 0; k < NCNT; k = k + 1) begin : g_cnt
            localparam DN = (k < `RCPWM_SHARED_IDX);
            reg [15:0] cnt_reg;
            reg [25:0] acc_reg;
            wire [12:0] fq;
            wire [22:0] inc;
            wire [26:0] acc_sum;
            wire acc_hit;
            wire [15:0] raw;
            wire [15:0] lim;
            wire [15:0] prel;
            wire tick;
            wire at_end;

            if (k < `RCPWM_SHARED_IDX) begin : g_own
                assign run[k] = en_reg[k]; // RULE1
            end else begin : g_shr
                assign run[k] = |en_reg[NCH-1:`RCPWM_SHARED_IDX]; // RULE1 RULE12
            end

            // per-mille step rate from a fractional accumulator, no divider needed
            assign fq = (freq_reg[k] > FMAX) ? FMAX : freq_reg[k]; // RULE19
            assign inc = {10'h000, fq} * {13'h0000, PM_MUL};
            assign acc_sum = {1'b0, acc_reg} + {4'h0, inc};
            assign acc_hit = acc_sum >= CLK_HZ; // RULE16

            // preloads that would exceed the frequency limit are clamped
            assign raw = reload_reg[k];
            assign lim = DN ? (ps_reg[k] ? ((raw < MIN_DN_PS) ? MIN_DN_PS : raw)
                                         : ((raw < MIN_DN) ? MIN_DN : raw))
                            : (ps_reg[k] ? ((raw > MAX_UP_PS) ? MAX_UP_PS : raw)
                                         : ((raw > MAX_UP) ? MAX_UP : raw)); // RULE19
            assign prel = pm_reg[k] ? (DN ? PM_RLD_DN : PM_RLD_UP) : lim; // RULE5 RULE16

            assign tick = pm_reg[k] ? acc_hit
                        : (DN ? (ps_reg[k] ? s_dn_ps : s_dn)
                              : (ps_reg[k] ? s_up_ps : s_up)); // RULE17
            assign at_end = DN ? (cnt_reg <= 16'h0001) : (cnt_reg == 16'hFFFF); // RULE4
            assign wrap[k] = run[k] & tick & at_end; // RULE4

            always @(posedge clk) begin
                if (rst) begin
                    cnt_reg <= 16'h0000; // RULE22
                    acc_reg <= 26'h0000000;
                end else if (!run[k]) begin
                    cnt_reg <= prel; // RULE1
                    acc_reg <= 26'h0000000;
                end else begin
                    acc_reg <= acc_hit ? acc_sum[25:0] - CLK_HZ[25:0] : acc_sum[25:0];
                    if (tick) begin
                        if (at_end) begin
                            cnt_reg <= prel; // RULE21
                        end else if (DN) begin
                            cnt_reg <= cnt_reg - 16'h0001; // RULE2 RULE21
                        end else begin
                            cnt_reg <= cnt_reg + 16'h0001; // RULE2 RULE21
                        end
                    end
                end
            end
            assign cnt_bus[k*16 +: 16] = cnt_reg;
        end
    endgenerate

    // channel comparators, dither and output stage
    genvar c;
    generate
        for (c = 0; c < NCH; c = c + 1) begin : g_ch
            localparam G = (c < `RCPWM_SHARED_IDX) ? c : `RCPWM_SHARED_IDX;
            localparam DNC = (c < `RCPWM_SHARED_IDX);
            reg lat_reg;
            reg ph_reg;
            reg out_reg;
            reg [15:0] dcnt_reg;
            wire [15:0] cnt = cnt_bus[G*16 +: 16];
            wire [16:0] duty17 = {1'b0, act_reg[c]};
            wire [16:0] amp17 = {1'b0, damp_reg[c]};
            wire [16:0] pmc;
            wire [16:0] base;
            wire [17:0] up_v;
            wire [16:0] dith_hi;
            wire [16:0] dith_lo;
            wire [16:0] cmp;
            wire [15:0] dlast;
            wire hit;
            wire act_on;
            wire on;

            assign pmc = (duty17 > PM_STEPS) ? PM_STEPS : duty17;
            // per-mille duty mapped onto a 1000-step period in the group's direction
            assign base = pm_reg[G] ? (DNC ? PM_STEPS - pmc : TOP - pmc) : duty17; // RULE16
            assign up_v = {1'b0, base} + {1'b0, amp17};
            assign dith_hi = (up_v > {1'b0, TOP}) ? TOP : up_v[16:0];
            assign dith_lo = (base > amp17) ? base - amp17 : 17'h00000;
            assign cmp = den_reg[c] ? (ph_reg ? dith_hi : dith_lo) : base; // RULE20
            assign dlast = (ddiv_reg[c] == 16'h0000) ? 16'h0000 : ddiv_reg[c] - 16'h0001;

            assign hit = ({1'b0, cnt} == cmp); // RULE3
            assign act_on = lat_reg | hit;
            // down group drives the load before the match, so compare equal preload is 0%
            assign on = DNC ? ~act_on : act_on; // RULE10 RULE11

            always @(posedge clk) begin
                if (rst) begin
                    lat_reg <= 1'b0;
                    ph_reg <= 1'b0;
                    out_reg <= 1'b0; // RULE22
                    dcnt_reg <= 16'h0000;
                end else if (!en_reg[c] || !run[G]) begin
                    lat_reg <= 1'b0;
                    ph_reg <= 1'b0;
                    out_reg <= 1'b0;
                    dcnt_reg <= 16'h0000;
                end else begin
                    if (wrap[G]) begin
                        lat_reg <= 1'b0; // RULE4
                    end else if (hit) begin
                        lat_reg <= 1'b1; // RULE3
                    end
                    out_reg <= on;
                    // phase flips every divider periods: full dither cycle is twice that
                    if (wrap[G] && den_reg[c]) begin
                        if (dcnt_reg >= dlast) begin
                            dcnt_reg <= 16'h0000;
                            ph_reg <= ~ph_reg; // RULE20
                        end else begin
                            dcnt_reg <= dcnt_reg + 16'h0001;
                        end
                    end
                end
            end
            assign out_bus[c] = out_reg;
        end
    endgenerate

    assign pwm_out = out_bus;
endmodule

// ==== pkg/rcpwm_regs.vh ====
// register offsets, field positions, reset values and timing counts of the pwm block
// Function
// RULE1: counter from cpu clock, starts on enable
// RULE2: channels 0-3 count down, shared up
// RULE3: compare match switches channel output
// RULE4: counter wrap clears output, new period
// RULE5: preload register sets shorter counting period
// RULE6: software keeps compare inside preload range
// RULE7: channels 0-3 each own preload register
// RULE8: software computes preload from counter clock
// RULE9: software picks prescaler for low frequencies
// RULE10: compare equal preload 0%, zero 100%
// RULE11: preload C350 gives 50000 duty steps
// RULE12: channels 4-11 share one preload
// RULE13: software computes shared preload from 10000h
// RULE14: software prescales shared group below 39 Hz
// RULE15: software never mixes modes within shared group
// RULE16: per-mille mode: hertz and per-mille duty
// RULE17: prescale select divides counter clock by 64; the shared group's prescale divides by 8 (2500000 Hz to 312500 Hz)
// RULE18: new duty applied only while change accepted
// RULE19: pwm frequency limited to 5 kHz
// RULE20: dither alternates duty at pwm/(2*divider)
// RULE21: down group reloads at one, up at FFFF
// RULE22: reset stops counters, outputs inactive
`ifndef RCPWM_REGS_VH
`define RCPWM_REGS_VH

`define RCPWM_OFS_CHAN_EN 12'h000
`define RCPWM_OFS_PRESCALE 12'h004
`define RCPWM_OFS_PERMILLE 12'h008
`define RCPWM_OFS_CHANGE 12'h00C
`define RCPWM_OFS_DITHER_EN 12'h010
`define RCPWM_OFS_OUT_STAT 12'h014
`define RCPWM_PAGE_CNT 4'h0
`define RCPWM_PAGE_CHAN 4'h1
`define RCPWM_BANK_RELOAD 3'h1
`define RCPWM_BANK_FREQ 3'h2
`define RCPWM_BANK_COUNT 3'h3
`define RCPWM_SUB_DUTY 2'h0
`define RCPWM_SUB_DAMP 2'h1
`define RCPWM_SUB_DDIV 2'h2
`define RCPWM_SUB_ACTIVE 2'h3
`define RCPWM_SHARED_IDX 4

`define RCPWM_RST_RELOAD_DN 16'hFFFF
`define RCPWM_RST_RELOAD_UP 16'h0000
`define RCPWM_RST_FREQ 13'h0064
`define RCPWM_RST_DUTY 16'h0000

`define RCPWM_CLK_HZ 40000000
`define RCPWM_DN_HZ 10000000
`define RCPWM_UP_HZ 2500000
`define RCPWM_UP_PS_HZ 312500
`define RCPWM_PS_DIV 64
`define RCPWM_DIV_DN (`RCPWM_CLK_HZ / `RCPWM_DN_HZ)
`define RCPWM_DIV_DN_PS (`RCPWM_DIV_DN * `RCPWM_PS_DIV)
`define RCPWM_DIV_UP (`RCPWM_CLK_HZ / `RCPWM_UP_HZ)
`define RCPWM_DIV_UP_PS (`RCPWM_CLK_HZ / `RCPWM_UP_PS_HZ)
`define RCPWM_FMAX_HZ 5000
`define RCPWM_TOP 65536
`define RCPWM_PM_STEPS 1000
`define RCPWM_MIN_RLD_DN ((`RCPWM_DN_HZ + `RCPWM_FMAX_HZ - 1) / `RCPWM_FMAX_HZ)
`define RCPWM_MIN_RLD_DN_PS ((`RCPWM_DN_HZ / `RCPWM_PS_DIV + `RCPWM_FMAX_HZ - 1) / `RCPWM_FMAX_HZ)
`define RCPWM_MAX_RLD_UP (`RCPWM_TOP - (`RCPWM_UP_HZ + `RCPWM_FMAX_HZ - 1) / `RCPWM_FMAX_HZ)
`define RCPWM_MAX_RLD_UP_PS (`RCPWM_TOP - (`RCPWM_UP_PS_HZ + `RCPWM_FMAX_HZ - 1) / `RCPWM_FMAX_HZ)

`endif

// ==== core/rcpwm_tick.v ====
// counter clock strobes derived from the cpu clock, plain and prescaled
`include "rcpwm_regs.vh"
module rcpwm_tick (
    // clock and reset
    input wire clk,
    input wire rst,
    // strobes, one cycle each
    output wire tick_dn,
    output wire tick_dn_ps,
    output wire tick_up,
    output wire tick_up_ps
);
    localparam integer DN_I = `RCPWM_DIV_DN - 1;
    localparam integer DN_PS_I = `RCPWM_DIV_DN_PS - 1;
    localparam integer UP_I = `RCPWM_DIV_UP - 1;
    localparam integer UP_PS_I = `RCPWM_DIV_UP_PS - 1;
    // masks cut to the divider width on purpose; every value fits
    localparam [7:0] M_DN = DN_I[7:0];
    localparam [7:0] M_DN_PS = DN_PS_I[7:0];
    localparam [7:0] M_UP = UP_I[7:0];
    localparam [7:0] M_UP_PS = UP_PS_I[7:0];

    reg [7:0] div_reg;
    reg [3:0] tick_reg;

    // one shared divider keeps all strobes phase aligned
    always @(posedge clk) begin
        if (rst) begin
            div_reg <= 8'h00;
            tick_reg <= 4'h0;
        end else begin
            div_reg <= div_reg + 8'h01;
            tick_reg[0] <= (div_reg & M_DN) == M_DN;
            tick_reg[1] <= (div_reg & M_DN_PS) == M_DN_PS; // RULE17
            tick_reg[2] <= (div_reg & M_UP) == M_UP;
            tick_reg[3] <= (div_reg & M_UP_PS) == M_UP_PS; // RULE17
        end
    end

    assign tick_dn = tick_reg[0];
    assign tick_dn_ps = tick_reg[1];
    assign tick_up = tick_reg[2];
    assign tick_up_ps = tick_reg[3];
endmodule

// ==== sim/rcpwm_props.sv ====
// checker of the pwm block register port and pin behaviour
`include "rcpwm_regs.vh"
module rcpwm_props (
    // clock and reset
    input wire clk,
    input wire rst,
    // register port
    input wire [11:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] rdata,
    // pwm pins
    input wire [11:0] pwm_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    // shadow of the change-accept bits, kept from the write strobe alone
    reg [11:0] chg_reg;
    always @(posedge clk) begin
        if (rst) begin
            chg_reg <= 12'h000;
        end else if (wr && addr == `RCPWM_OFS_CHANGE) begin
            chg_reg <= wdata[11:0];
        end
    end
    // no disable here: the reset itself is the cause
    property p_rst_out;
        rst |=> pwm_out == 12'h000;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("pins not idle after reset");
    property p_rd_idle;
        disable iff (rst) !rd |=> rdata == 32'h00000000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read answer");
    property p_unmapped;
        disable iff (rst) rd && addr == 12'h018 |=> rdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_dis;
        disable iff (rst) (wr && addr == `RCPWM_OFS_CHAN_EN && wdata[11:0] == 12'h000) ##1 (!wr) [*3]
            |-> pwm_out == 12'h000;
    endproperty
    a_dis: assert property (p_dis) else $error("disabled channels still drive");
    property p_stat;
        disable iff (rst) rd && addr == `RCPWM_OFS_OUT_STAT |=> rdata == {20'h00000, $past(pwm_out)};
    endproperty
    a_stat: assert property (p_stat) else $error("status differs from pins");
    property p_upper;
        disable iff (rst) rd && addr >= 12'h020 && addr <= 12'h030 |=> rdata[31:16] == 16'h0000;
    endproperty
    a_upper: assert property (p_upper) else $error("preload read upper bits set");
    property p_reload;
        disable iff (rst) $past(wr, 2) && $past(addr, 2) == 12'h020 && $past(wdata[15:0], 2) >= 16'h07D0 &&
            !$past(wr) && rd && addr == 12'h020 |=> rdata[15:0] == $past(wdata[15:0], 3);
    endproperty
    a_reload: assert property (p_reload) else $error("preload not kept");
    property p_duty;
        disable iff (rst) $past(wr, 2) && $past(addr, 2) == 12'h120 && $past(chg_reg[2], 2) && !$past(wr) &&
            rd && addr == 12'h12C |=> rdata[15:0] == $past(wdata[15:0], 3);
    endproperty
    a_duty: assert property (p_duty) else $error("accepted duty not active");
endmodule
bind rcpwm_top rcpwm_props u_props (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pwm_out(pwm_out));

// ==== sim/rcpwm_load.sv ====
// load model: counts the cycles each pwm pin switches its load on
module rcpwm_load (
    // clock and reset
    input wire clk,
    input wire rst,
    // pins seen by the loads
    input wire [11:0] pwm_out,
    // accumulated on-time per pin
    output logic [31:0] on_cnt [12]
);
    timeunit 1ns;
    timeprecision 100ps;
    // an unknown pin never counts as on, so it cannot pass for a match
    always @(posedge clk) begin
        for (int c = 0; c < 12; c++) begin
            if (rst) begin
                on_cnt[c] <= 32'h00000000;
            end else if (pwm_out[c] === 1'b1) begin
                on_cnt[c] <= on_cnt[c] + 32'h00000001;
            end
        end
    end
endmodule

// ==== sim/reload_compare_pwm_channels_bench.sv ====
// testbench: register setup and on-time measurement of the pwm pins
`include "rcpwm_regs.vh"
module reload_compare_pwm_channels_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h00000000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [11:0] pwm_out;
    logic [31:0] on_cnt [12];
    logic [31:0] base [12];
    logic [31:0] rv;
    int num_errors = 0;
    int comparisons = 0;
    always #12.5 clk = ~clk;
    rcpwm_top uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .pwm_out(pwm_out));
    rcpwm_load load (.clk(clk), .rst(rst), .pwm_out(pwm_out), .on_cnt(on_cnt));
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // a window of whole periods gives the on-time whatever the phase
    task automatic measure(input int len);
        @(posedge clk);
        #1;
        for (int c = 0; c < 12; c++) base[c] = on_cnt[c];
        repeat (len) @(posedge clk);
        #1;
        for (int c = 0; c < 12; c++) base[c] = on_cnt[c] - base[c];
    endtask
    task automatic t_reset;
        rd_reg(12'h020, rv);
        check("reload0", 32'h0000FFFF, rv);
        rd_reg(12'h030, rv);
        check("reload4", 32'h00000000, rv);
        rd_reg(12'h040, rv);
        check("freq0", 32'h00000064, rv);
        rd_reg(12'h018, rv);
        check("unmapped", 32'h00000000, rv);
        check("pins", 32'h00000000, {20'h00000, pwm_out});
        $display("test reset done");
    endtask
    task automatic t_run_a;
        logic [15:0] duty [7];
        logic [31:0] exp [7];
        duty = '{16'h01F4, 16'h07D0, 16'h0000, 16'h0019, 16'hFF06, 16'hFE0C, 16'hFFFF};
        exp = '{32'h5DC0, 32'h0000, 32'h7D00, 32'h6400, 32'h3E80, 32'h7D00, 32'h0040};
        wr_reg(12'h024, 32'h07D0);
        wr_reg(12'h028, 32'h07D0);
        wr_reg(12'h02C, 32'h007D);
        wr_reg(12'h030, 32'hFE0C);
        wr_reg(12'h020, 32'h07D0);
        rd_reg(12'h020, rv);
        check("reload0 back", 32'h000007D0, rv);
        // shared group runs at 5 kHz, far above the point where it would need the prescaler
        wr_reg(`RCPWM_OFS_PRESCALE, 32'h08);
        for (int c = 0; c < 7; c++) wr_reg(12'h100 + 12'h010 * c, {16'h0000, duty[c]});
        wr_reg(`RCPWM_OFS_CHANGE, 32'h0FFF);
        wr_reg(`RCPWM_OFS_CHAN_EN, 32'h007F);
        // 32000 cycles hold whole periods of every channel set up here
        measure(32000);
        for (int c = 0; c < 7; c++) begin
            check($sformatf("on ch%0d", c), exp[c], base[c]);
        end
        rd_reg(`RCPWM_OFS_OUT_STAT, rv);
        check("status", 32'h00000024, rv & 32'h00000026);
        $display("test periods done");
    endtask
    task automatic t_change;
        wr_reg(`RCPWM_OFS_CHANGE, 32'h0FFB);
        wr_reg(12'h120, 32'h0777);
        rd_reg(12'h12C, rv);
        check("held duty", 32'h00000000, rv);
        rd_reg(12'h120, rv);
        check("shadow duty", 32'h00000777, rv);
        wr_reg(`RCPWM_OFS_CHANGE, 32'h0FFF);
        wr_reg(12'h120, 32'h0555);
        rd_reg(12'h12C, rv);
        check("taken duty", 32'h00000555, rv);
        $display("test change done");
    endtask
    task automatic t_run_b;
        wr_reg(`RCPWM_OFS_CHAN_EN, 32'h0000);
        repeat (4) @(posedge clk);
        #1;
        check("stopped pins", 32'h00000000, {20'h00000, pwm_out});
        wr_reg(`RCPWM_OFS_PRESCALE, 32'h00);
        wr_reg(12'h020, 32'h0064);
        wr_reg(12'h100, 32'h0032);
        wr_reg(`RCPWM_OFS_PERMILLE, 32'h02);
        wr_reg(12'h044, 32'h1388);
        wr_reg(12'h110, 32'h00FA);
        wr_reg(12'h120, 32'h0064);
        wr_reg(12'h124, 32'h01F4);
        wr_reg(12'h128, 32'h0001);
        wr_reg(`RCPWM_OFS_DITHER_EN, 32'h0004);
        wr_reg(`RCPWM_OFS_CHAN_EN, 32'h0007);
        // two periods hold one lowered (clamped to full on) and one raised dither phase
        measure(16000);
        check("clamped ch0", 32'h3CF0, base[0]);
        check("per mille ch1", 32'h0FA0, base[1]);
        check("dither ch2", 32'h3520, base[2]);
        // reset in mid-run while pins are driven: pins drop at once, setup is lost
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        #1;
        check("pins in reset", 32'h00000000, {20'h00000, pwm_out});
        @(posedge clk);
        rst <= 1'b0;
        rd_reg(12'h020, rv);
        check("reload0 after reset", 32'h0000FFFF, rv);
        $display("test clamp and per mille done");
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_run_a;
        t_change;
        t_run_b;
        end_sim;
    end
    // a hang is cut short well above the planned run length
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        end_sim;
    end
endmodule
